// [rtl/acgpd_top.sv]
// Purpose: per-channel gain trim, polarity inversion and pooled delay lines on a sample stream
// Assumes: one sample per channel per sample period; AXI4-Lite control
// Notes: staged settings reach the audio only on commit
`include "acgpd_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module acgpd_fifo #(
	parameter int W = 31,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] cnt;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic rdy;
	} acgpd_fifo_s;
	acgpd_fifo_s r_reg, r_next;
	logic [W-1:0] mem [0:DEPTH-1];
	logic push, pop;
	assign push = in_valid && r_reg.rdy;
	assign pop = out_valid && out_ready;
	assign in_ready = r_reg.rdy;
	assign out_valid = (r_reg.cnt != '0);
	assign out_data = mem[r_reg.rd];
	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.wr = r_reg.wr + 1'b1;
		end
		if (pop) begin
			r_next.rd = r_reg.rd + 1'b1;
		end
		r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		r_next.rdy = (r_next.cnt < (AW+1)'(DEPTH));
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '{cnt: '0, rd: '0, wr: '0, rdy: 1'b0};
		end else begin
			r_reg <= r_next;
		end
		if (push) begin
			mem[r_reg.wr] <= in_data;
		end
	end
endmodule : acgpd_fifo

module acgpd_top #(
	parameter int NUM_CH = 128,
	parameter int DW = 24,
	parameter int STEP_LOG = `ACGPD_STEP_LOG,
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// routed samples in
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [6:0] s_chan,
	input wire logic [DW-1:0] s_data,
	// processed samples out
	output logic m_valid,
	input wire logic m_ready,
	output logic [6:0] m_chan,
	output logic [DW-1:0] m_data
);
	import acgpd_pkg::*;
	localparam int SEG = 6 + STEP_LOG;
	localparam int PW = SEG + 2;
	localparam int MW = SEG + 7;
	localparam logic [DW-1:0] MAXV = {1'b0, {(DW-1){1'b1}}};
	localparam logic [DW-1:0] MINV = {1'b1, {(DW-1){1'b0}}};
	typedef struct packed {
		acgpd_phase_e phase;
		logic [6:0] idx;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [6:0] ch_sel;
		logic [6:0] el_sel;
		logic [1:0] mode_stg;
		logic [1:0] mode_act;
		logic [6:0] eng_cnt;
		logic eng_up;
		logic [17:0] eng_coef;
		logic [127:0] map_vld;
		logic m_valid;
		logic [6:0] m_chan;
		logic [DW-1:0] m_data;
	} acgpd_top_s;
	acgpd_top_s r_reg, r_next;
	// ****************************************
	// setting and delay memories
	// ****************************************
	logic [17:0] stg_coef [0:127];
	logic [17:0] act_coef [0:127];
	logic [6:0] stg_gain [0:127];
	logic stg_inv [0:127];
	logic act_inv [0:127];
	logic [6:0] stg_ech [0:127];
	logic [8:0] stg_est [0:127];
	logic [8:0] act_est [0:127];
	logic [6:0] map_elem [0:127];
	logic [PW-1:0] wp [0:127];
	logic [DW-1:0] dmem [0:(1<<MW)-1];
	// ****************************************
	// input buffer
	// ****************************************
	logic ff_valid, ff_ready;
	logic [6:0] ff_chan;
	logic [DW-1:0] ff_data;
	acgpd_fifo #(.W(DW+7), .DEPTH(FIFO_DEPTH)) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(s_valid),
		.in_ready(s_ready),
		.in_data({s_chan, s_data}),
		.out_valid(ff_valid),
		.out_ready(ff_ready),
		.out_data({ff_chan, ff_data})
	);
	// ****************************************
	// sample path
	// ****************************************
	logic fire, hit;
	logic [6:0] e;
	logic [4:0] sh;
	logic [PW-1:0] mask, dsamp, rd_ptr;
	logic [8:0] max_steps, steps;
	logic [MW-1:0] base, rd_addr, wr_addr;
	logic [DW-1:0] delayed, gained, outv;
	logic [DW+18:0] prod;
	logic [DW+2:0] scaled;
	assign ff_ready = fire;
	assign e = map_elem[ff_chan];
	assign hit = r_reg.map_vld[ff_chan];
	assign sh = 5'(SEG) + 5'(r_reg.mode_act);
	assign mask = PW'((1 << sh) - 1);
	assign max_steps = `ACGPD_BASE_STEPS << r_reg.mode_act;
	assign steps = (act_est[e] > max_steps) ? max_steps : act_est[e];
	assign dsamp = PW'(steps) << STEP_LOG;
	assign rd_ptr = (wp[e] - dsamp) & mask;
	assign base = MW'(e) << sh;
	assign rd_addr = base | MW'(rd_ptr);
	assign wr_addr = base | MW'(wp[e] & mask);
	assign delayed = hit ? dmem[rd_addr] : ff_data;
	assign prod = $signed(delayed) * $signed({1'b0, act_coef[ff_chan]});
	assign scaled = prod[DW+18:16];
	always_comb begin
		if ($signed(scaled) > $signed({{3{1'b0}}, MAXV})) begin
			gained = MAXV;
		end else if ($signed(scaled) < $signed({{3{1'b1}}, MINV})) begin
			gained = MINV;
		end else begin
			gained = scaled[DW-1:0];
		end
		if (act_inv[ff_chan]) begin
			outv = (gained == MINV) ? MAXV : -gained;
		end else begin
			outv = gained;
		end
	end
	// ****************************************
	// control and bus
	// ****************************************
	logic do_wr, wr_bad, eng_done, el_live;
	logic [6:0] gclip, gabs;
	logic [34:0] eng_prod;
	assign do_wr = r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid && (r_reg.phase == ACGPD_IDLE);
	assign gclip = ($signed(r_reg.w_data[6:0]) > $signed(`ACGPD_GAIN_LIMIT)) ? `ACGPD_GAIN_LIMIT :
		($signed(r_reg.w_data[6:0]) < -$signed(`ACGPD_GAIN_LIMIT)) ? -`ACGPD_GAIN_LIMIT : r_reg.w_data[6:0];
	assign gabs = gclip[6] ? -gclip : gclip;
	assign eng_prod = r_reg.eng_coef * (r_reg.eng_up ? `ACGPD_COEF_UP : `ACGPD_COEF_DN);
	assign eng_done = (r_reg.phase == ACGPD_ENG) && (r_reg.eng_cnt == 7'h00);
	// element exists in the active mode and carries a delay
	assign el_live = ({1'b0, r_reg.idx} < 8'(`ACGPD_ELEMS >> r_reg.mode_act)) && (stg_est[r_reg.idx] != 9'h000);
	assign wr_bad = !(r_reg.aw_addr inside {`ACGPD_OFF_CTRL, `ACGPD_OFF_STATUS, `ACGPD_OFF_CH_SEL, `ACGPD_OFF_CH_CFG,
		`ACGPD_OFF_EL_SEL, `ACGPD_OFF_EL_CFG});
	always_comb begin
		r_next = r_reg;
		fire = ff_valid && (!r_reg.m_valid || m_ready) && (r_reg.phase inside {ACGPD_IDLE, ACGPD_ENG});
		if (r_reg.m_valid && m_ready) begin
			r_next.m_valid = 1'b0;
		end
		if (fire) begin
			r_next.m_valid = 1'b1;
			r_next.m_chan = ff_chan;
			r_next.m_data = outv;
		end
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.aw_ok = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.w_ok = 1'b1;
			r_next.w_data = s_axi_wdata;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (do_wr) begin
			r_next.aw_ok = 1'b0;
			r_next.w_ok = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = wr_bad ? `ACGPD_RESP_SLVERR : `ACGPD_RESP_OKAY;
			case (r_reg.aw_addr)
				`ACGPD_OFF_CTRL: begin
					r_next.mode_stg = (r_reg.w_data[2:1] > `ACGPD_MODE_MAX) ? `ACGPD_MODE_MAX : r_reg.w_data[2:1];
					if (r_reg.w_data[`ACGPD_CTRL_COMMIT]) begin
						r_next.mode_act = r_next.mode_stg;
						r_next.phase = ACGPD_CPY_CH;
						r_next.idx = 7'h00;
					end
				end
				`ACGPD_OFF_CH_SEL: r_next.ch_sel = r_reg.w_data[6:0];
				`ACGPD_OFF_EL_SEL: r_next.el_sel = r_reg.w_data[6:0];
				`ACGPD_OFF_CH_CFG: begin
					r_next.phase = ACGPD_ENG;
					r_next.eng_cnt = gabs;
					r_next.eng_up = !gclip[6];
					r_next.eng_coef = `ACGPD_COEF_UNITY;
				end
				default: begin
				end
			endcase
		end
		r_next.awready = !r_next.aw_ok && !r_next.bvalid;
		r_next.wready = !r_next.w_ok && !r_next.bvalid;
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = `ACGPD_RESP_OKAY;
			case (s_axi_araddr)
				`ACGPD_OFF_CTRL: r_next.rdata = {29'h0, r_reg.mode_stg, 1'b0};
				`ACGPD_OFF_STATUS: r_next.rdata = {29'h0, r_reg.mode_act, r_reg.phase != ACGPD_IDLE};
				`ACGPD_OFF_CH_SEL: r_next.rdata = {25'h0, r_reg.ch_sel};
				`ACGPD_OFF_CH_CFG: r_next.rdata = {23'h0, stg_inv[r_reg.ch_sel], 1'b0, stg_gain[r_reg.ch_sel]};
				`ACGPD_OFF_EL_SEL: r_next.rdata = {25'h0, r_reg.el_sel};
				`ACGPD_OFF_EL_CFG: r_next.rdata = {15'h0, stg_est[r_reg.el_sel], 1'b0, stg_ech[r_reg.el_sel]};
				default: begin
					r_next.rdata = 32'h0;
					r_next.rresp = `ACGPD_RESP_SLVERR;
				end
			endcase
		end
		r_next.arready = !r_next.rvalid;
		case (r_reg.phase)
			ACGPD_INIT, ACGPD_CPY_EL: begin
				r_next.idx = r_reg.idx + 7'h01;
				if (r_reg.idx == 7'h7F) begin
					r_next.phase = ACGPD_IDLE;
				end
			end
			ACGPD_ENG: begin
				r_next.eng_cnt = r_reg.eng_cnt - 7'h01;
				r_next.eng_coef = eng_prod[33:16];
				if (eng_done) begin
					r_next.phase = ACGPD_IDLE;
				end
			end
			ACGPD_CPY_CH: begin
				r_next.map_vld[r_reg.idx] = 1'b0;
				r_next.idx = r_reg.idx + 7'h01;
				if (r_reg.idx == 7'(NUM_CH - 1)) begin
					r_next.phase = ACGPD_CPY_EL;
					r_next.idx = 7'h00;
				end
			end
			default: begin
			end
		endcase
		if ((r_reg.phase == ACGPD_CPY_EL) && el_live) begin
			r_next.map_vld[stg_ech[r_reg.idx]] = 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '{phase: ACGPD_INIT, mode_stg: `ACGPD_MODE_RST, mode_act: `ACGPD_MODE_RST, bresp: `ACGPD_RESP_OKAY,
				rresp: `ACGPD_RESP_OKAY, default: '0};
		end else begin
			r_reg <= r_next;
		end
		if (r_reg.phase == ACGPD_INIT) begin
			stg_coef[r_reg.idx] <= `ACGPD_COEF_UNITY;
			act_coef[r_reg.idx] <= `ACGPD_COEF_UNITY;
			stg_gain[r_reg.idx] <= 7'h00;
			stg_inv[r_reg.idx] <= 1'b0;
			act_inv[r_reg.idx] <= 1'b0;
			stg_ech[r_reg.idx] <= 7'h00;
			stg_est[r_reg.idx] <= 9'h000;
			act_est[r_reg.idx] <= 9'h000;
			wp[r_reg.idx] <= '0;
		end
		if (do_wr && (r_reg.aw_addr == `ACGPD_OFF_CH_CFG)) begin
			stg_gain[r_reg.ch_sel] <= gclip;
			stg_inv[r_reg.ch_sel] <= r_reg.w_data[`ACGPD_CHCFG_INV];
		end
		if (eng_done) begin
			stg_coef[r_reg.ch_sel] <= r_reg.eng_coef;
		end
		if (do_wr && (r_reg.aw_addr == `ACGPD_OFF_EL_CFG)) begin
			stg_ech[r_reg.el_sel] <= r_reg.w_data[6:0];
			stg_est[r_reg.el_sel] <= r_reg.w_data[16:8];
		end
		if (r_reg.phase == ACGPD_CPY_CH) begin
			act_coef[r_reg.idx] <= stg_coef[r_reg.idx];
			act_inv[r_reg.idx] <= stg_inv[r_reg.idx];
		end
		if (r_reg.phase == ACGPD_CPY_EL) begin
			act_est[r_reg.idx] <= stg_est[r_reg.idx];
			if (el_live) begin
				map_elem[stg_ech[r_reg.idx]] <= r_reg.idx;
			end
		end
		if (fire && hit) begin
			dmem[wr_addr] <= ff_data;
			wp[e] <= (wp[e] + 1'b1) & mask;
		end
	end
	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready = r_reg.wready;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rresp = r_reg.rresp;
	assign s_axi_rdata = r_reg.rdata;
	assign m_valid = r_reg.m_valid;
	assign m_chan = r_reg.m_chan;
	assign m_data = r_reg.m_data;
	// ****************************************
	// checks
	// ****************************************
	logic plain, unity;
	assign unity = !hit && (act_coef[ff_chan] == `ACGPD_COEF_UNITY);
	assign plain = fire && unity && (ff_data != MINV);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_OUT_HOLD: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data)) else $error("output dropped");
	AST_NO_FIRE_COPY: assert property (r_reg.phase inside {ACGPD_CPY_CH, ACGPD_CPY_EL} |-> !fire) else $error("audio during commit");
	AST_INVERT: assert property (plain && act_inv[ff_chan] |=> m_data == -$past(ff_data)) else $error("inversion wrong");
	AST_PASS: assert property (plain && !act_inv[ff_chan] |=> m_data == $past(ff_data)) else $error("unity gain altered data");
	AST_SAT: assert property (fire && !act_inv[ff_chan] && ($signed(scaled) > $signed({3'h0, MAXV})) |=> m_data == MAXV)
		else $error("no saturation");
	AST_ENG_LEN: assert property ($rose(r_reg.phase == ACGPD_ENG) |-> ##[1:61] r_reg.phase == ACGPD_IDLE) else $error("gain engine stuck");
	AST_COMMIT_LEN: assert property ($rose(r_reg.phase == ACGPD_CPY_CH) |-> ##[128:256] r_reg.phase == ACGPD_IDLE)
		else $error("commit length wrong");
	AST_SEGMENT: assert property (fire && hit |-> (rd_addr >> sh) == MW'(e) && {1'b0, e} < 8'(`ACGPD_ELEMS >> r_reg.mode_act))
		else $error("delay outside element segment");
	AST_DELAY_RANGE: assert property (fire && hit |-> steps >= 9'h001 && steps <= max_steps)
		else $error("delay out of range");
	AST_GAIN_RANGE: assert property (eng_done |-> r_reg.eng_coef <= 18'h1FFD0 && r_reg.eng_coef >= 18'h0800C)
		else $error("gain beyond six dB");
	COV_COMMIT: cover property (r_reg.phase == ACGPD_CPY_EL ##1 r_reg.phase == ACGPD_IDLE);
	COV_DELAY: cover property (fire && hit);
	COV_INVERT: cover property (fire && act_inv[ff_chan]);
	COV_SAT: cover property (fire && ($signed(scaled) > $signed({3'h0, MAXV})));
endmodule : acgpd_top
`default_nettype wire

// [rtl/acgpd_defines.svh]
// Purpose: offsets, fields, reset values and counts of the channel gain, phase and delay block
// Assumes: 32-bit AXI4-Lite register words, byte offsets
// Notes: definitions only
`ifndef ACGPD_DEFINES_SVH
`define ACGPD_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define ACGPD_OFF_CTRL 8'h00
`define ACGPD_OFF_STATUS 8'h04
`define ACGPD_OFF_CH_SEL 8'h08
`define ACGPD_OFF_CH_CFG 8'h0C
`define ACGPD_OFF_EL_SEL 8'h10
`define ACGPD_OFF_EL_CFG 8'h14
// ****************************************
// fields and reset values
// ****************************************
`define ACGPD_CTRL_COMMIT 0
`define ACGPD_CTRL_MODE_LSB 1
`define ACGPD_CHCFG_INV 8
`define ACGPD_ELCFG_STEP_LSB 8
`define ACGPD_MODE_RST 2'h0
`define ACGPD_MODE_MAX 2'h2
`define ACGPD_RESP_OKAY 2'h0
`define ACGPD_RESP_SLVERR 2'h2
// ****************************************
// gain and delay scaling
// ****************************************
`define ACGPD_GAIN_LIMIT 7'h3C
`define ACGPD_COEF_UNITY 18'h10000
`define ACGPD_COEF_UP 17'h102F7
`define ACGPD_COEF_DN 17'h0FD12
`define ACGPD_ELEMS 128
`define ACGPD_BASE_STEPS 9'h040
`define ACGPD_STEP_LOG 8
`endif

// [rtl/acgpd_pkg.sv]
// Purpose: shared types of the channel gain, phase and delay block
// Assumes: nothing
// Notes: constants live in acgpd_defines.svh
package acgpd_pkg;
	typedef enum logic [2:0] {ACGPD_INIT, ACGPD_IDLE, ACGPD_ENG, ACGPD_CPY_CH, ACGPD_CPY_EL} acgpd_phase_e;
endpackage : acgpd_pkg

// [verification/acgpd_tb_top.sv]
// Purpose: self-checking bench of the channel gain, phase and delay block
// Assumes: STEP_LOG of 1, so one delay step is two samples of a channel
// Notes: gain checks allow a small rounding margin of the coefficient engine
`include "acgpd_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module acgpd_tb_top;
	import acgpd_pkg::*;
	localparam int DW = 24;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_valid = 1'b0, m_ready = 1'b1, s_ready, m_valid;
	logic [6:0] s_chan = 7'h00, m_chan;
	logic [DW-1:0] s_data = 24'h0, m_data;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	// ****************************************
	// device and clock
	// ****************************************
	acgpd_top #(.STEP_LOG(1)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_valid(s_valid), .s_ready(s_ready),
		.s_chan(s_chan), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready), .m_chan(m_chan),
		.m_data(m_data));
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			complete_run();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_near(input logic [DW-1:0] got, input real exp);
		real g;
		real tol;
		g = $itor($signed(got));
		tol = (exp < 0.0 ? -exp : exp) * 0.003 + 2.0;
		cmp_count++;
		if ((^got === 1'bx) || g - exp > tol || exp - g > tol) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, 24'($rtoi(exp)));
		end
	endtask : chk_near
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd
	task automatic wait_idle();
		logic [31:0] st;
		do rd(`ACGPD_OFF_STATUS, st, `ACGPD_RESP_OKAY); while (st[0] !== 1'b0);
	endtask : wait_idle
	task automatic commit(input logic [1:0] m);
		wr(`ACGPD_OFF_CTRL, {29'h0, m, 1'b1}, `ACGPD_RESP_OKAY);
		wait_idle();
	endtask : commit
	task automatic set_ch(input logic [6:0] ch, input logic [6:0] g, input logic inv);
		wr(`ACGPD_OFF_CH_SEL, {25'h0, ch}, `ACGPD_RESP_OKAY);
		wr(`ACGPD_OFF_CH_CFG, {23'h0, inv, 1'b0, g}, `ACGPD_RESP_OKAY);
	endtask : set_ch
	task automatic set_el(input logic [6:0] e, input logic [6:0] ch, input logic [8:0] st);
		wr(`ACGPD_OFF_EL_SEL, {25'h0, e}, `ACGPD_RESP_OKAY);
		wr(`ACGPD_OFF_EL_CFG, {15'h0, st, 1'b0, ch}, `ACGPD_RESP_OKAY);
	endtask : set_el
	task automatic xfer(input logic [6:0] ch, input logic [DW-1:0] d, output logic [DW-1:0] q);
		s_valid <= 1'b1;
		s_chan <= ch;
		s_data <= d;
		do @(posedge aclk); while (s_ready !== 1'b1);
		s_valid <= 1'b0;
		do @(posedge aclk); while (m_valid !== 1'b1);
		q = m_data;
		chk({25'h0, m_chan}, {25'h0, ch});
	endtask : xfer
	function automatic real gexp(input int g, input real v);
		int gc;
		gc = g > 60 ? 60 : (g < -60 ? -60 : g);
		return v * $pow(10.0, gc / 200.0);
	endfunction : gexp
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] d;
		rd(`ACGPD_OFF_STATUS, d, `ACGPD_RESP_OKAY);
		chk({31'h0, d[0]}, 32'h1);
		wait_idle();
		rd(`ACGPD_OFF_STATUS, d, `ACGPD_RESP_OKAY);
		chk(d, 32'h0);
		rd(8'h18, d, `ACGPD_RESP_SLVERR);
		chk(d, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF, `ACGPD_RESP_SLVERR);
		$display("test regs done");
	endtask : t_regs
	task automatic t_gain();
		int gs[6] = '{1, -1, 60, -60, 63, -64};
		logic [6:0] chs[6] = '{7'h00, 7'h01, 7'h02, 7'h7F, 7'h04, 7'h05};
		logic [DW-1:0] q;
		xfer(7'h03, 24'h100000, q);
		chk({8'h0, q}, 32'h00100000);
		set_ch(7'h03, 7'h0A, 1'b1);
		for (int i = 0; i < 6; i++) set_ch(chs[i], 7'(gs[i]), 1'b0);
		xfer(7'h03, 24'h100000, q);
		chk({8'h0, q}, 32'h00100000);
		commit(2'h0);
		xfer(7'h03, 24'h100000, q);
		chk_near(q, -gexp(10, 1048576.0));
		for (int i = 0; i < 6; i++) begin
			xfer(chs[i], 24'h200000, q);
			chk_near(q, gexp(gs[i], 2097152.0));
		end
		$display("test gain done");
	endtask : t_gain
	task automatic t_sat();
		logic [DW-1:0] q;
		set_ch(7'h09, 7'h3C, 1'b0);
		set_ch(7'h0A, 7'h00, 1'b1);
		commit(2'h0);
		xfer(7'h09, 24'h7FFFFF, q);
		chk({8'h0, q}, 32'h007FFFFF);
		xfer(7'h09, 24'h800000, q);
		chk({8'h0, q}, 32'h00800000);
		xfer(7'h0A, 24'h800000, q);
		chk({8'h0, q}, 32'h007FFFFF);
		xfer(7'h0A, 24'h000001, q);
		chk({8'h0, q}, 32'h00FFFFFF);
		$display("test saturation done");
	endtask : t_sat
	task automatic t_mode();
		logic [31:0] d;
		logic [1:0] prev;
		prev = 2'h0;
		for (int m = 0; m < 4; m++) begin
			wr(`ACGPD_OFF_CTRL, {29'h0, 2'(m), 1'b0}, `ACGPD_RESP_OKAY);
			rd(`ACGPD_OFF_STATUS, d, `ACGPD_RESP_OKAY);
			chk({30'h0, d[2:1]}, {30'h0, prev});
			commit(2'(m));
			prev = (m == 3) ? 2'h2 : 2'(m);
			rd(`ACGPD_OFF_STATUS, d, `ACGPD_RESP_OKAY);
			chk({30'h0, d[2:1]}, {30'h0, prev});
		end
		$display("test mode done");
	endtask : t_mode
	task automatic t_delay();
		logic [DW-1:0] q;
		set_el(7'h01, 7'h14, 9'h001);
		set_el(7'h28, 7'h15, 9'h001);
		set_el(7'h02, 7'h16, 9'h1FF);
		commit(2'h2);
		for (int k = 0; k < 6; k++) begin
			xfer(7'h14, 24'(k + 1), q);
			if (k >= 2) chk({8'h0, q}, 32'(k - 1));
			xfer(7'h15, 24'(k + 1), q);
			chk({8'h0, q}, 32'(k + 1));
		end
		for (int k = 0; k < 520; k++) begin
			xfer(7'h16, 24'(k + 1), q);
			if (k >= 512) chk({8'h0, q}, 32'(k - 511));
		end
		commit(2'h0);
		for (int k = 0; k < 4; k++) begin
			xfer(7'h14, 24'(k + 1), q);
			if (k >= 2) chk({8'h0, q}, 32'(k - 1));
			xfer(7'h15, 24'(k + 1), q);
			if (k >= 2) chk({8'h0, q}, 32'(k - 1));
		end
		$display("test delay done");
	endtask : t_delay
	task automatic t_fifo();
		int n;
		n = 0;
		m_ready <= 1'b0;
		s_valid <= 1'b1;
		s_chan <= 7'h1E;
		s_data <= 24'h0;
		while (n < 40) begin
			@(posedge aclk);
			if (s_ready !== 1'b1 && n > 0) break;
			if (s_ready === 1'b1) n++;
			s_data <= 24'(n);
		end
		s_valid <= 1'b0;
		chk(32'(n >= 32 && n <= 34), 32'h1);
		m_ready <= 1'b1;
		for (int i = 0; i < n; i++) begin
			do @(posedge aclk); while (m_valid !== 1'b1);
			chk({8'h0, m_data}, 32'(i));
		end
		@(posedge aclk);
		chk({31'h0, m_valid}, 32'h0);
		$display("test fifo done");
	endtask : t_fifo
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_gain();
		t_sat();
		t_mode();
		t_delay();
		t_fifo();
		complete_run();
	end
endmodule : acgpd_tb_top
`default_nettype wire
